// ==== common/hai_pkg.sv ====
// shared constants and types of the haptic amplifier two-wire register port
// assumes a single 20 MHz system clock and an open-drain data wire with pull-up
package hai_pkg;

  // system clock and fastest supported bus clock
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned SCL_MAX_HZ    = 400000;
  // shortest scl half period in system clocks, rounded down
  localparam int unsigned SCL_HALF_CYC  = CLK_HZ / (2 * SCL_MAX_HZ);

  // address byte layout
  localparam int unsigned RW_POS        = 0;
  localparam logic [4:0]  ADDR_FIXED_HI = 5'h0d;  // upper five address bits
  localparam logic [6:0]  ADDR_GENERIC  = 7'h0e;  // pin-independent address

  // register file geometry and reset values
  localparam int unsigned PTR_W         = 8;
  localparam int unsigned REG_W         = 16;
  localparam int unsigned REG_DEPTH     = 256;
  localparam logic [15:0] REG_RST_VAL   = 16'h0000;
  localparam logic [7:0]  PTR_RST_VAL   = 8'h00;

  // bit counter values
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h7;

  // synchroniser lanes
  localparam int unsigned SYNC_W        = 4;
  localparam logic [3:0]  SYNC_RST_VAL  = 4'h3;   // scl and sda idle high

  // controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACK  = 6'h04,
    ST_TX   = 6'h08,
    ST_HACK = 6'h10,
    ST_SKIP = 6'h20
  } hai_state_t;

  // kind of byte being received
  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_PTR  = 2'h1,
    K_DATA = 2'h2
  } hai_kind_t;

endpackage : hai_pkg

// ==== rtl/hai_sync.sv ====
// two-flop synchroniser, one lane per bit
// assumes asynchronous inputs from pins; reset value given per lane
`timescale 1ns/1ns
`default_nettype none
module hai_sync
  import hai_pkg::*;
#(
  parameter int unsigned     W       = SYNC_W,
  parameter logic [W-1:0]    RST_VAL = SYNC_RST_VAL
)(
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  din,
  output var  logic [W-1:0]  dout
);

  // one pair of flops per lane; first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      logic meta_q;
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q  <= RST_VAL[i];
          dout[i] <= RST_VAL[i];
        end
        else
        begin
          meta_q  <= din[i];
          dout[i] <= meta_q;
        end
      end
    end
  endgenerate

endmodule : hai_sync
`default_nettype wire

// ==== rtl/hai_reg_mem.sv ====
// 256 x 16 control register storage, one write port, registered read port
// assumes writes and reads are issued by the bus port on the same clock
`timescale 1ns/1ns
`default_nettype none
module hai_reg_mem
  import hai_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              we,
  input  wire logic [PTR_W-1:0]  waddr,
  input  wire logic [REG_W-1:0]  wdata,
  input  wire logic [PTR_W-1:0]  raddr,
  output var  logic [REG_W-1:0]  rdata
);

  logic [REG_W-1:0] mem [REG_DEPTH];

  // storage array, no reset so it maps onto ram
  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // read data leaves from a register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= REG_RST_VAL;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule : hai_reg_mem
`default_nettype wire

// ==== rtl/hai_i2c_target.sv ====
// two-wire target port reaching the 16-bit control registers
// assumes scl/sda and address pins are asynchronous; sda is open drain
`timescale 1ns/1ns
`default_nettype none
module hai_i2c_target
  import hai_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output var  logic              sda_out,
  output var  logic              sda_oe,
  input  wire logic              addr_select_low_pin,
  input  wire logic              addr_select_high_pin,
  output var  logic              reg_wr_valid,
  output var  logic [PTR_W-1:0]  reg_wr_addr,
  output var  logic [REG_W-1:0]  reg_wr_data
);

  // whole state of the port
  typedef struct packed {
    hai_state_t        st;
    hai_kind_t         kind;
    logic [3:0]        bit_cnt;
    logic [7:0]        shift;
    logic [7:0]        upper_data_byte;
    logic [PTR_W-1:0]  ptr;
    logic              half;
    logic              rw;
    logic              scl_p;
    logic              sda_p;
    logic              oe;
    logic              wr;
    logic [PTR_W-1:0]  wr_addr;
    logic [REG_W-1:0]  wr_data;
  } hai_port_t;

  localparam hai_port_t PORT_RST = '{
    st: ST_IDLE, kind: K_ADDR, bit_cnt: 4'h0, shift: 8'h00,
    upper_data_byte: 8'h00, ptr: PTR_RST_VAL, half: 1'b0, rw: 1'b0,
    scl_p: 1'b1, sda_p: 1'b1, oe: 1'b0, wr: 1'b0,
    wr_addr: PTR_RST_VAL, wr_data: REG_RST_VAL};

  hai_port_t         q;
  hai_port_t         d;
  logic [3:0]        sync_o;
  logic              s_scl;
  logic              s_sda;
  logic              s_sel_lo;
  logic              s_sel_hi;
  logic [REG_W-1:0]  mem_rd;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic              addr_match;

  // pins pass two flops before use
  hai_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST_VAL)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .din   ({addr_select_high_pin, addr_select_low_pin, sda_in, scl_in}),
    .dout  (sync_o)
  );
  assign s_scl    = sync_o[0];
  assign s_sda    = sync_o[1];
  assign s_sel_lo = sync_o[2];
  assign s_sel_hi = sync_o[3];

  // register storage; a pair is committed one cycle after it completes
  hai_reg_mem u_mem (
    .clock (clock),
    .rst_n (rst_n),
    .we    (q.wr),
    .waddr (q.wr_addr),
    .wdata (q.wr_data),
    .raddr (q.ptr),
    .rdata (mem_rd)
  );

  // bus events; scl phases are many clocks long at fast mode
  assign scl_rise  = s_scl & ~q.scl_p;
  assign scl_fall  = ~s_scl & q.scl_p;
  assign start_det = s_scl & q.scl_p & q.sda_p & ~s_sda;
  assign stop_det  = s_scl & q.scl_p & ~q.sda_p & s_sda;

  // address decode: pin-selected or generic
  assign addr_match = (q.shift[7:1] == {ADDR_FIXED_HI, s_sel_hi, s_sel_lo})
                    | (q.shift[7:1] == ADDR_GENERIC);

  // next-state logic
  always_comb
  begin
    d       = q;
    d.scl_p = s_scl;
    d.sda_p = s_sda;
    d.wr    = 1'b0;
    if (start_det)
    begin
      // start or repeated start: next byte is an address
      d.st      = ST_RX;
      d.kind    = K_ADDR;
      d.bit_cnt = 4'h0;
      d.half    = 1'b0;
      d.oe      = 1'b0;
    end
    else if (stop_det)
    begin
      // a pending upper byte is dropped here
      d.st   = ST_IDLE;
      d.half = 1'b0;
      d.oe   = 1'b0;
    end
    else
    begin
      case (q.st)
        ST_RX:
        begin
          if (scl_rise && q.bit_cnt != BITS_PER_BYTE)
          begin
            d.shift   = {q.shift[6:0], s_sda};  // msb arrives first
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
          else if (scl_fall && q.bit_cnt == BITS_PER_BYTE)
          begin
            d.st = ST_ACK;
            d.oe = 1'b1;
            case (q.kind)
              K_ADDR:
              begin
                if (addr_match)
                begin
                  d.rw = q.shift[RW_POS];
                end
                else
                begin
                  d.st = ST_SKIP;  // no ack, stay off the wire
                  d.oe = 1'b0;
                end
              end
              K_PTR:
              begin
                d.ptr = q.shift;
              end
              default:
              begin
                if (!q.half)
                begin
                  d.upper_data_byte = q.shift;  // upper byte first
                  d.half            = 1'b1;
                end
                else
                begin
                  d.wr      = 1'b1;  // whole pair only
                  d.wr_addr = q.ptr;
                  d.wr_data = {q.upper_data_byte, q.shift};
                  d.ptr     = q.ptr + 8'h01;
                  d.half    = 1'b0;
                end
              end
            endcase
          end
        end
        ST_ACK:
        begin
          // ack held through the ninth clock, released on its fall
          if (scl_fall)
          begin
            d.bit_cnt = 4'h0;
            d.oe      = 1'b0;
            if (q.kind == K_ADDR && q.rw)
            begin
              d.st    = ST_TX;  // upper byte first
              d.shift = mem_rd[15:8];
              d.half  = 1'b0;
              d.oe    = ~mem_rd[15];
            end
            else
            begin
              d.st   = ST_RX;
              d.kind = (q.kind == K_ADDR) ? K_PTR : K_DATA;
            end
          end
        end
        ST_TX:
        begin
          // only pulls low for zero bits, never touches scl
          if (scl_fall)
          begin
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == LAST_TX_BIT)
            begin
              d.st = ST_HACK;
              d.oe = 1'b0;
            end
            else
            begin
              d.shift = {q.shift[6:0], 1'b0};
              d.oe    = ~q.shift[6];
            end
          end
        end
        ST_HACK:
        begin
          if (scl_rise)
          begin
            if (s_sda)
            begin
              d.st = ST_SKIP;  // host nack: release and wait
            end
            else if (q.half)
            begin
              d.ptr = q.ptr + 8'h01;
            end
          end
          else if (scl_fall)
          begin
            d.st      = ST_TX;
            d.bit_cnt = 4'h0;
            if (!q.half)
            begin
              d.shift = mem_rd[7:0];  // lower byte after host ack
              d.half  = 1'b1;
              d.oe    = ~mem_rd[7];
            end
            else
            begin
              d.shift = mem_rd[15:8];  // next pair
              d.half  = 1'b0;
              d.oe    = ~mem_rd[15];
            end
          end
        end
        ST_IDLE, ST_SKIP:
        begin
          d.oe = 1'b0;
        end
        default:
        begin
          d = PORT_RST;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= PORT_RST;
    end
    else
    begin
      q <= d;
    end
  end
  // open-drain drive and write report
  assign sda_out      = 1'b0;
  assign sda_oe       = q.oe;
  assign reg_wr_valid = q.wr;
  assign reg_wr_addr  = q.wr_addr;
  assign reg_wr_data  = q.wr_data;
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_idle_quiet;
    (q.st == ST_IDLE || q.st == ST_SKIP) |-> !sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("sda pulled while idle");
  property p_no_ack_foreign;
    (q.st == ST_RX && q.kind == K_ADDR && scl_fall && q.bit_cnt == BITS_PER_BYTE && !addr_match && !start_det
      && !stop_det) |=> (q.st == ST_SKIP) ##1 !sda_oe;
  endproperty
  a_no_ack_foreign: assert property (p_no_ack_foreign) else $error("foreign address acknowledged");
  property p_ack_own;
    (q.st == ST_RX && q.kind == K_ADDR && scl_fall && q.bit_cnt == BITS_PER_BYTE && addr_match && !start_det
      && !stop_det) |=> (q.st == ST_ACK && sda_oe && q.rw == $past(q.shift[RW_POS]));
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("own address not acknowledged");
  property p_start_addr;
    start_det |=> (q.st == ST_RX && q.kind == K_ADDR && q.bit_cnt == 4'h0 && !sda_oe);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start did not restart address");
  property p_pair_commit;
    reg_wr_valid |-> (reg_wr_data[15:8] == q.upper_data_byte && q.ptr == reg_wr_addr + 8'h01 && !q.half);
  endproperty
  a_pair_commit: assert property (p_pair_commit) else $error("bad pair commit");
  property p_stop_no_write;
    stop_det |=> !reg_wr_valid ##1 !reg_wr_valid;
  endproperty
  a_stop_no_write: assert property (p_stop_no_write) else $error("write after stop");
  property p_tx_stable;
    (q.st == ST_TX && s_scl && q.scl_p) |-> $stable(sda_oe);
  endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("sda moved while scl high");
  property p_read_step;
    (q.st == ST_HACK && scl_rise && !s_sda && q.half && !start_det && !stop_det)
      |=> q.ptr == $past(q.ptr) + 8'h01;
  endproperty
  a_read_step: assert property (p_read_step) else $error("pointer did not step on ack");
  property p_nack_release;
    (q.st == ST_HACK && scl_rise && s_sda && !start_det && !stop_det) |=> (q.st == ST_SKIP) [*2];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("nack not honoured");
  property p_ptr_load;
    (q.st == ST_RX && q.kind == K_PTR && scl_fall && q.bit_cnt == BITS_PER_BYTE && !start_det && !stop_det)
      |=> (q.ptr == $past(q.shift) && sda_oe);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not taken");
  // main scenarios worth seeing
  c_write_pair: cover property (reg_wr_valid);
  c_read_lower: cover property (q.st == ST_HACK && q.half && scl_rise && !s_sda);
  c_nack: cover property (q.st == ST_HACK && scl_rise && s_sda);
  c_foreign: cover property (q.st == ST_SKIP && q.kind == K_ADDR);
endmodule : hai_i2c_target
`default_nettype wire

// ==== test/hai_host_model.sv ====
// host bus controller model driving scl and the controller side of sda
// assumes the bench resolves the open-drain sda wire and drives on falling clock edges
`timescale 1ns/1ns
`default_nettype none
module hai_host_model
  import hai_pkg::*;
(
  input  wire logic clock,
  output var  logic scl,
  output var  logic sda_drv,
  input  wire logic sda
);
  // bus idles released, high by pull-up
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // wait n falling clock edges
  task automatic hw(input int n);
    repeat (n) @(negedge clock);
  endtask : hw

  // one bit: data set in low phase, wire sampled mid high, 400 kHz
  task automatic bit_io(input logic b, output logic s);
    hw(SCL_HALF_CYC / 2);
    sda_drv = b;
    hw(SCL_HALF_CYC - SCL_HALF_CYC / 2);
    scl = 1'b1;
    hw(SCL_HALF_CYC / 2);
    s = sda;
    hw(SCL_HALF_CYC - SCL_HALF_CYC / 2);
    scl = 1'b0;
  endtask : bit_io

  // start, also serves as repeated start before a read address
  task automatic start_c;
    hw(SCL_HALF_CYC / 2);
    sda_drv = 1'b1;
    hw(SCL_HALF_CYC / 2);
    scl = 1'b1;
    hw(SCL_HALF_CYC / 2);
    sda_drv = 1'b0;
    hw(SCL_HALF_CYC / 2);
    scl = 1'b0;
  endtask : start_c

  // stop: sda rises while scl high
  task automatic stop_c;
    hw(SCL_HALF_CYC / 2);
    sda_drv = 1'b0;
    hw(SCL_HALF_CYC / 2);
    scl = 1'b1;
    hw(SCL_HALF_CYC / 2);
    sda_drv = 1'b1;
    hw(SCL_HALF_CYC);
  endtask : stop_c

  // send a byte msb first, then release for the target's ack
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // read a byte msb first, then answer ack or nack
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask : recv_byte
endmodule : hai_host_model
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench of the two-wire register port
// assumes a pull-up on sda; writes are observed on the reg_wr ports
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import hai_pkg::*;
;
  logic        clock;
  logic        rst_n;
  logic        pin_lo;
  logic        pin_hi;
  logic        scl_w;
  logic        host_sda;
  logic        sda_w;
  logic        sda_out;
  logic        sda_oe;
  logic        reg_wr_valid;
  logic [7:0]  reg_wr_addr;
  logic [15:0] reg_wr_data;
  logic [23:0] wq[$];
  int          mismatches;
  int          total_checks;

  // open-drain wire: low if either party pulls
  assign sda_w = (sda_oe ? sda_out : 1'b1) & host_sda;

  hai_i2c_target dut_u (
    .clock                (clock),
    .rst_n                (rst_n),
    .scl_in               (scl_w),
    .sda_in               (sda_w),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .addr_select_low_pin  (pin_lo),
    .addr_select_high_pin (pin_hi),
    .reg_wr_valid         (reg_wr_valid),
    .reg_wr_addr          (reg_wr_addr),
    .reg_wr_data          (reg_wr_data)
  );

  hai_host_model host_u (
    .clock   (clock),
    .scl     (scl_w),
    .sda_drv (host_sda),
    .sda     (sda_w)
  );

  // collect every reported register write, sampled mid-cycle where the pulse has settled
  always @(negedge clock)
    if (reg_wr_valid === 1'b1)
      wq.push_back({reg_wr_addr, reg_wr_data});

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask : chk

  task automatic send_chk(input logic [7:0] d, input logic exp, input string what);
    logic a;
    host_u.send_byte(d, a);
    chk({23'h0, a}, {23'h0, exp}, what);
  endtask : send_chk

  task automatic recv_chk(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    host_u.recv_byte(ack, d);
    chk({16'h0, d}, {16'h0, exp}, "read byte");
  endtask : recv_chk

  // two pairs from pointer 0xff, second lands at 0x00
  task automatic test_write;
    pin_hi = 1'b1;
    host_u.start_c();
    send_chk({ADDR_FIXED_HI, 2'b10, 1'b0}, 1'b1, "address ack");
    send_chk(8'hff, 1'b1, "pointer ack");
    send_chk(8'ha5, 1'b1, "upper ack");
    send_chk(8'hc3, 1'b1, "lower ack");
    send_chk(8'h1e, 1'b1, "second upper ack");
    send_chk(8'h7f, 1'b1, "second lower ack");
    host_u.stop_c();
    chk(24'(wq.size()), 24'd2, "write count");
    chk(wq.pop_front(), 24'hffa5c3, "first write");
    chk(wq.pop_front(), 24'h001e7f, "second write");
    $display("write test done");
  endtask : test_write

  // read both pairs back via the generic address, nack at the end
  task automatic test_read;
    logic busy;
    busy = 1'b0;
    host_u.start_c();
    send_chk(8'h1c, 1'b1, "generic write address");
    send_chk(8'hff, 1'b1, "pointer ack");
    host_u.start_c();
    send_chk(8'h1d, 1'b1, "generic read address");
    recv_chk(1'b1, 8'ha5);
    recv_chk(1'b1, 8'hc3);
    recv_chk(1'b1, 8'h1e);
    recv_chk(1'b0, 8'h7f);
    repeat (2 * SCL_HALF_CYC) @(negedge clock)
      if (sda_oe !== 1'b0)
        busy = 1'b1;
    chk({23'h0, busy}, 24'h0, "sda released after nack");
    host_u.stop_c();
    // pin-selected read of register 0x00, host refuses the upper byte
    host_u.start_c();
    send_chk({ADDR_FIXED_HI, 2'b10, 1'b0}, 1'b1, "pin write address");
    send_chk(8'h00, 1'b1, "pointer ack");
    host_u.start_c();
    send_chk({ADDR_FIXED_HI, 2'b10, 1'b1}, 1'b1, "pin read address");
    recv_chk(1'b0, 8'h1e);
    host_u.stop_c();
    $display("read test done");
  endtask : test_read

  // every pin setting: own address acked, another one ignored
  task automatic test_pins;
    for (int p = 0; p < 4; p++)
    begin
      {pin_hi, pin_lo} = 2'(p);
      host_u.start_c();
      send_chk({ADDR_FIXED_HI, 2'(p), 1'b0}, 1'b1, "pin address ack");
      host_u.stop_c();
      host_u.start_c();
      send_chk({ADDR_FIXED_HI, ~2'(p), 1'b0}, 1'b0, "foreign address");
      send_chk(8'h00, 1'b0, "byte after foreign address");
      host_u.stop_c();
    end
    chk(24'(wq.size()), 24'd0, "no writes");
    $display("pin test done");
  endtask : test_pins

  // upper byte only, then stop: nothing written
  task automatic test_half;
    host_u.start_c();
    send_chk(8'h1c, 1'b1, "generic write address");
    send_chk(8'h10, 1'b1, "pointer ack");
    send_chk(8'h55, 1'b1, "upper ack");
    host_u.stop_c();
    chk(24'(wq.size()), 24'd0, "half pair dropped");
    $display("half pair test done");
  endtask : test_half

  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // reset, then the scenarios
  initial
  begin
    rst_n = 1'b0;
    pin_lo = 1'b0;
    pin_hi = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    test_write();
    test_read();
    test_pins();
    test_half();
    final_report();
  end

  // watchdog, about two and a half times the 16k cycles the tests need
  initial
  begin
    repeat (40000) @(posedge clock);
    mismatches++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
